// *** pss_pkg.sv ***
/*
 * Package for the primary start-up and brownout sequencer: timing
 * constants, soft-start endpoints, sequencer states and the packed
 * structs that carry comparator levels and secondary status.
 * Assumes a single 250 MHz clock.
 */
package pss_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned OCP_TIMEOUT_MS   = 55;
   localparam int unsigned SOFT_PERIOD_US   = 9600;
   localparam int unsigned BO_TIMEOUT_MS    = 60;
   localparam int unsigned OCP_CYCLES       = OCP_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int unsigned SOFT_CYCLES      = SOFT_PERIOD_US * CLK_MHZ;
   localparam int unsigned BO_CYCLES        = BO_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int unsigned SS_STEPS         = 256;

   // ************************************************************
   // Soft-start endpoints, millivolts and kilohertz
   // ************************************************************
   localparam logic [11:0] PEAK_LIMIT_FLOOR_MV   = 12'h064;
   localparam logic [11:0] PEAK_LIMIT_CEILING_MV = 12'h190;
   localparam logic [11:0] FREQ_SOFT_KHZ         = 12'h018;
   localparam logic [11:0] FREQ_MAX_KHZ          = 12'h055;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [3:0] {
      PSS_CHARGE,
      PSS_QUALIFY,
      PSS_RECHARGE,
      PSS_BROWNOUT,
      PSS_DECIDE,
      PSS_AUTONOMOUS,
      PSS_SECONDARY,
      PSS_PROTECT
   } pss_state_t;

   // Comparator levels: rail vs thresholds, line vs thresholds
   typedef struct packed {
      logic line_powered;
      logic above_source_off;
      logic below_rail_min;
      logic below_auto_restart;
      logic above_brown_in;
      logic above_brownout;
   } pss_levels_t;

   typedef struct packed {
      logic seen;
      logic active;
      logic protect;
   } pss_sec_t;

   typedef struct packed {
      logic        switch_en;
      logic        autonomous;
      logic [11:0] peak_limit_mv;
      logic [11:0] freq_khz;
   } pss_drive_t;

endpackage

// *** pss_ramp.sv ***
/*
 * Linear soft-start ramp of peak limit and switching frequency.
 * Assumes a one-cycle step enable from the caller's divider.
 */
`timescale 1ns/100ps
module pss_ramp #(
   parameter int unsigned STEPS = pss_pkg::SS_STEPS
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Control
   input  wire logic        start_i,
   input  wire logic        step_i,
   // Ramp outputs
   output logic [11:0]      peak_o,
   output logic [11:0]      freq_o,
   output logic             done_o
);
   import pss_pkg::*;

   initial begin
      if (STEPS < 2 || STEPS > 4096) $error("pss_ramp: bad STEPS");
   end

   localparam logic [23:0] PK_SPAN =
      24'(PEAK_LIMIT_CEILING_MV - PEAK_LIMIT_FLOOR_MV);
   localparam logic [23:0] FQ_SPAN = 24'(FREQ_MAX_KHZ - FREQ_SOFT_KHZ);
   localparam logic [12:0] LAST    = 13'(STEPS);

   logic [12:0] step_reg, step_next;
   logic [11:0] peak_reg, peak_next;
   logic [11:0] freq_reg, freq_next;

   // ************************************************************
   // Ramp
   // ************************************************************
   always_comb begin
      step_next = step_reg;
      if (start_i) begin
         step_next = '0;
      end else if (step_i && step_reg != LAST) begin
         step_next = step_reg + 13'h001;
      end
      // Interpolate each endpoint pair so rounding never overshoots
      peak_next = PEAK_LIMIT_FLOOR_MV +
         12'((PK_SPAN * 24'(step_next)) / 24'(LAST));
      freq_next = FREQ_SOFT_KHZ +
         12'((FQ_SPAN * 24'(step_next)) / 24'(LAST));
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         step_reg <= '0;
         peak_reg <= PEAK_LIMIT_FLOOR_MV;
         freq_reg <= FREQ_SOFT_KHZ;
      end else begin
         step_reg <= step_next;
         peak_reg <= peak_next;
         freq_reg <= freq_next;
      end
   end

   assign peak_o = peak_reg;
   assign freq_o = freq_reg;
   assign done_o = (step_reg == LAST);

endmodule

// *** pss_sequencer.sv ***
/*
 * Primary start-up and brownout sequencer: charging source control,
 * brown-in/brownout qualification, three start-up paths, start-up
 * over-current timer, brownout timer and soft-start.
 * Assumes comparator and secondary-status inputs are synchronous to
 * mclk_i; they are still double registered against glitch timing.
 */
`timescale 1ns/100ps

// Function
// R1: Charge rail from line source; stop at source-off level.
// R2: Qualify line only after the charging source is off.
// R3: Brown-in above 107V: recharge to source-off, then start up.
// R4: No brown-in: brownout, no switching, cycle rail source on/off.
// R5: Sample secondary status after rail passes source-off level.
// R6: No status: switch autonomously, hand over when secondary active.
// R7: Over-current timer from soft-start; expiry stops, flags, protects.
// R8: Over-current timer expires after 55ms without secondary start.
// R9: Secondary already active: skip autonomous switching, hand over.
// R10: Secondary protection before start: never switch, flag, protect.
// R11: Brownout timer runs below 98V, clears above it.
// R12: Brownout timeout: protect and hiccup rail 8.3V to source-off.
// R13: After brownout, restart only on a new valid brown-in.
// R14: Line detection suspended while charging source is on.
// R15: Soft-start ramps peak limit 0.1V to 0.4V over 9.6ms.
// R16: Soft-start raises frequency 24kHz to 85kHz over that period.
// R17: Auto-restart level: clear flag, enable source, restart logic.
// R18: Synchronise inputs; timers are counters on the clock.
module pss_sequencer #(
   parameter int unsigned OCP_CYC  = pss_pkg::OCP_CYCLES,
   parameter int unsigned SOFT_CYC = pss_pkg::SOFT_CYCLES,
   parameter int unsigned BO_CYC   = pss_pkg::BO_CYCLES
) (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // Comparators and secondary status
   input  wire pss_pkg::pss_levels_t levels_i,
   input  wire pss_pkg::pss_sec_t    sec_i,
   // Outputs
   output logic                      source_en_o,
   output pss_pkg::pss_drive_t       drive_o,
   output logic                      startup_overcurrent_flag_o,
   output logic                      protect_flag_o,
   output logic                      brownout_o,
   output pss_pkg::pss_state_t       state_o
);
   import pss_pkg::*;

   initial begin
      if (OCP_CYC < 1 || SOFT_CYC < SS_STEPS || BO_CYC < 1)
         $error("pss_sequencer: bad timing parameters");
   end

   localparam int unsigned STEP_DIV = SOFT_CYC / SS_STEPS;
   localparam logic [31:0] OCP_LAST = 32'(OCP_CYC - 1);
   localparam logic [31:0] BO_LAST  = 32'(BO_CYC - 1);
   localparam logic [31:0] DIV_LAST = 32'(STEP_DIV - 1);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   pss_levels_t lv_meta_reg, lv_reg;
   pss_sec_t    sc_meta_reg, sc_reg;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         lv_meta_reg <= '0;
         lv_reg      <= '0;
         sc_meta_reg <= '0;
         sc_reg      <= '0;
      end else begin
         lv_meta_reg <= levels_i;      // [R18]
         lv_reg      <= lv_meta_reg;
         sc_meta_reg <= sec_i;         // [R18]
         sc_reg      <= sc_meta_reg;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   pss_state_t  state_reg, state_next;
   logic        src_reg, src_next;
   logic        ocpf_reg, ocpf_next;
   logic        prot_reg, prot_next;
   logic        bo_reg, bo_next;
   logic        sw_reg, sw_next;
   logic        auto_reg, auto_next;
   logic [31:0] ocp_cnt_reg, ocp_cnt_next;
   logic [31:0] bo_cnt_reg, bo_cnt_next;
   logic [31:0] div_reg, div_next;
   logic        ss_start, ss_step, ss_done;
   logic [11:0] ramp_peak, ramp_freq;

   always_comb begin
      state_next   = state_reg;
      src_next     = src_reg;
      ocpf_next    = ocpf_reg;
      prot_next    = prot_reg;
      bo_next      = bo_reg;
      sw_next      = 1'b0;
      auto_next    = 1'b0;
      ocp_cnt_next = ocp_cnt_reg;
      bo_cnt_next  = '0;
      div_next     = div_reg;
      ss_start     = 1'b0;
      ss_step      = 1'b0;
      if (!lv_reg.line_powered) begin
         // Line gone: state restarts from charging with source off; flags held
         state_next = PSS_CHARGE;
         src_next   = 1'b0;
      end else begin
         case (state_reg)
            PSS_CHARGE: begin
               src_next = 1'b1;                               // [R1]
               if (lv_reg.above_source_off) begin
                  src_next   = 1'b0;                          // [R1]
                  state_next = PSS_QUALIFY;
               end
            end
            PSS_QUALIFY: begin
               // Source already off, so no resistor drop on the line
               if (!src_reg) begin                       // [R2] [R14]
                  if (lv_reg.above_brown_in) begin
                     bo_next    = 1'b0;                   // [R3] [R13]
                     src_next   = 1'b1;                   // [R3]
                     state_next = PSS_RECHARGE;
                  end else begin
                     bo_next    = 1'b1;                       // [R4]
                     state_next = PSS_BROWNOUT;
                  end
               end
            end
            PSS_RECHARGE: begin
               src_next = 1'b1;
               if (lv_reg.above_source_off) begin
                  src_next   = 1'b0;                          // [R3]
                  state_next = PSS_DECIDE;
               end
            end
            PSS_BROWNOUT: begin
               // Hiccup the rail; requalify each time the source stops
               if (lv_reg.below_rail_min) begin
                  src_next = 1'b1;                       // [R4] [R12]
               end else if (src_reg && lv_reg.above_source_off) begin
                  src_next   = 1'b0;
                  state_next = PSS_QUALIFY;                  // [R13]
               end
            end
            PSS_DECIDE: begin
               // Status sampled with rail at source-off level
               if (sc_reg.protect) begin
                  prot_next  = 1'b1;                         // [R10]
                  state_next = PSS_PROTECT;                  // [R5]
               end else if (sc_reg.active) begin
                  state_next = PSS_SECONDARY;             // [R5] [R9]
               end else begin
                  ss_start     = 1'b1;                       // [R15]
                  ocp_cnt_next = '0;                          // [R7]
                  div_next     = '0;
                  state_next   = PSS_AUTONOMOUS;              // [R6]
               end
            end
            PSS_AUTONOMOUS: begin
               sw_next      = 1'b1;                           // [R6]
               auto_next    = 1'b1;
               ocp_cnt_next = ocp_cnt_reg + 32'h1;            // [R18]
               if (div_reg == DIV_LAST) begin
                  div_next = '0;
                  ss_step  = !ss_done;                  // [R15] [R16]
               end else begin
                  div_next = div_reg + 32'h1;
               end
               if (sc_reg.protect) begin
                  sw_next    = 1'b0;
                  auto_next  = 1'b0;
                  prot_next  = 1'b1;
                  state_next = PSS_PROTECT;
               end else if (sc_reg.active) begin
                  state_next = PSS_SECONDARY;                 // [R6]
               end else if (ocp_cnt_reg == OCP_LAST) begin
                  sw_next    = 1'b0;                      // [R7] [R8]
                  auto_next  = 1'b0;
                  ocpf_next  = 1'b1;                          // [R7]
                  state_next = PSS_PROTECT;
               end
            end
            PSS_SECONDARY: begin
               sw_next = 1'b1;                                // [R9]
               if (!lv_reg.above_brownout) begin
                  bo_cnt_next = bo_cnt_reg + 32'h1;          // [R11]
               end
               if (sc_reg.protect) begin
                  sw_next    = 1'b0;
                  prot_next  = 1'b1;
                  state_next = PSS_PROTECT;
               end else if (bo_cnt_reg == BO_LAST) begin
                  sw_next    = 1'b0;                         // [R12]
                  bo_next    = 1'b1;
                  prot_next  = 1'b1;
                  state_next = PSS_BROWNOUT;                 // [R13]
               end
            end
            PSS_PROTECT: begin
               src_next = 1'b0;
               if (lv_reg.below_auto_restart) begin
                  ocpf_next  = 1'b0;                         // [R17]
                  prot_next  = 1'b0;
                  src_next   = 1'b1;
                  state_next = PSS_CHARGE;
               end
            end
            default: begin
               state_next = PSS_CHARGE;
               src_next   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg   <= PSS_CHARGE;
         src_reg     <= 1'b0;
         ocpf_reg    <= 1'b0;
         prot_reg    <= 1'b0;
         bo_reg      <= 1'b0;
         sw_reg      <= 1'b0;
         auto_reg    <= 1'b0;
         ocp_cnt_reg <= '0;
         bo_cnt_reg  <= '0;
         div_reg     <= '0;
      end else begin
         state_reg   <= state_next;
         src_reg     <= src_next;
         ocpf_reg    <= ocpf_next;
         prot_reg    <= prot_next;
         bo_reg      <= bo_next;
         sw_reg      <= sw_next;
         auto_reg    <= auto_next;
         ocp_cnt_reg <= ocp_cnt_next;
         bo_cnt_reg  <= bo_cnt_next;
         div_reg     <= div_next;
      end
   end

   // ************************************************************
   // Soft-start ramp
   // ************************************************************
   pss_ramp #(
      .STEPS (SS_STEPS)
   ) u_ramp (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .start_i (ss_start),
      .step_i  (ss_step),
      .peak_o  (ramp_peak),
      .freq_o  (ramp_freq),
      .done_o  (ss_done)
   );

   // ************************************************************
   // Outputs
   // ************************************************************
   assign source_en_o                = src_reg;
   assign drive_o.switch_en          = sw_reg;
   assign drive_o.autonomous         = auto_reg;
   assign drive_o.peak_limit_mv      = ramp_peak;
   assign drive_o.freq_khz           = ramp_freq;
   assign startup_overcurrent_flag_o = ocpf_reg;
   assign protect_flag_o             = prot_reg;
   assign brownout_o                 = bo_reg;
   assign state_o                    = state_reg;

endmodule

// *** pss_sec_model.sv ***
/* Secondary controller model driving the status link.
 * Assumes the bench sets the mode before the decision point. */
`timescale 1ns/100ps
module pss_sec_model
   import pss_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // Mode from bench, switching from primary
   input  wire logic [1:0]  mode_i,
   input  wire logic [7:0]  delay_i,
   input  wire logic        switch_i,
   // Status link
   output pss_pkg::pss_sec_t sec_o
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic       act;

   always_comb begin
      cnt_next = cnt_reg;
      if (switch_i && cnt_reg != delay_i) begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      cnt_reg <= rst_i ? 8'h00 : cnt_next;
   end

   // Mode 1 up before start, mode 3 wakes after switching
   assign act   = (mode_i == 2'h1) || (mode_i == 2'h3 && cnt_reg == delay_i);
   assign sec_o = '{act, act, mode_i == 2'h2};
endmodule

// *** pss_sequencer_assertions.sv ***
/* Port checker for the start-up sequencer.
 * Assumes the bench's short timer parameters via the bind. */
`timescale 1ns/100ps
module pss_sequencer_assertions
   import pss_pkg::*;
#(
   parameter int unsigned OCP_CYC  = 100,
   parameter int unsigned SOFT_CYC = 512,
   parameter int unsigned BO_CYC   = 50
) (
   // Clock and reset
   input wire logic                 mclk_i,
   input wire logic                 rst_i,
   // Inputs
   input wire pss_pkg::pss_levels_t levels_i,
   input wire pss_pkg::pss_sec_t    sec_i,
   // Outputs
   input wire logic                 source_en_o,
   input wire pss_pkg::pss_drive_t  drive_o,
   input wire logic                 startup_overcurrent_flag_o,
   input wire logic                 protect_flag_o,
   input wire logic                 brownout_o,
   input wire pss_pkg::pss_state_t  state_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // ***********************
   // Cycle counters
   // ***********************
   logic [31:0] auto_reg, auto_next, bo_reg, bo_next;
   always_comb begin
      auto_next = (state_o == PSS_AUTONOMOUS) ? auto_reg + 1 : '0;
      bo_next   = (state_o == PSS_SECONDARY && !levels_i.above_brownout)
                  ? bo_reg + 1 : '0;
   end
   always_ff @(posedge mclk_i) begin
      auto_reg <= rst_i ? '0 : auto_next;
      bo_reg   <= rst_i ? '0 : bo_next;
   end

   sequence s_prot_decide;
      sec_i.protect [*4] ##0 (state_o == PSS_DECIDE);
   endsequence
   sequence s_act_decide;
      (sec_i.active && !sec_i.protect) [*4] ##0 (state_o == PSS_DECIDE);
   endsequence
   sequence s_quiet_decide;
      (!sec_i.active && !sec_i.protect) [*4] ##0 (state_o == PSS_DECIDE);
   endsequence
   sequence s_auto_on;
      (state_o == PSS_AUTONOMOUS) ##[1:2]
      (drive_o.switch_en && drive_o.autonomous);
   endsequence

   // ***********************
   // Properties
   // ***********************
   AST_SRC_CHARGE: assert property ((state_o == PSS_CHARGE &&
      levels_i.line_powered && !levels_i.above_source_off) [*5]
      |=> source_en_o) else $error("charging source not on");
   AST_SRC_STOP: assert property (levels_i.above_source_off [*4] |->
      !(source_en_o && state_o == PSS_CHARGE)) else $error("source left on");
   AST_QUALIFY_SRC_OFF: assert property (state_o == PSS_QUALIFY
      |-> !source_en_o) else $error("qualify with source on");
   AST_NO_SWITCH: assert property ((state_o inside {PSS_CHARGE,
      PSS_QUALIFY, PSS_BROWNOUT, PSS_PROTECT} && state_o == $past(state_o))
      |-> !drive_o.switch_en) else $error("switching while idle");
   AST_DECIDE_PROTECT: assert property (s_prot_decide |=>
      (state_o == PSS_PROTECT && !drive_o.switch_en) ##[0:2] protect_flag_o)
      else $error("protect status not honoured");
   AST_DECIDE_ACTIVE: assert property (s_act_decide |=>
      (state_o == PSS_SECONDARY && !drive_o.autonomous))
      else $error("active secondary not handed control");
   AST_DECIDE_AUTO: assert property (s_quiet_decide |=> s_auto_on)
      else $error("no autonomous start");
   AST_HANDOVER: assert property (($rose(sec_i.active) &&
      !sec_i.protect && state_o == PSS_AUTONOMOUS) |-> ##[1:6]
      (state_o == PSS_SECONDARY)) else $error("no handover");
   AST_OCP_BOUND: assert property (auto_reg <= OCP_CYC + 2)
      else $error("start-up timer overran");
   AST_BO_TIMER: assert property ((state_o == PSS_BROWNOUT &&
      $past(state_o) == PSS_SECONDARY) |-> $past(bo_reg) >= BO_CYC)
      else $error("brownout too early");
   AST_RAMP_MONO: assert property ((state_o == PSS_AUTONOMOUS &&
      $past(state_o) == PSS_AUTONOMOUS && $past(state_o, 2) == PSS_AUTONOMOUS)
      |-> (drive_o.peak_limit_mv >= $past(drive_o.peak_limit_mv) &&
      drive_o.freq_khz >= $past(drive_o.freq_khz))) else $error("ramp fell");
   AST_AUTO_RESTART: assert property ((state_o == PSS_PROTECT &&
      levels_i.below_auto_restart) [*3] |-> ##[1:3] (state_o == PSS_CHARGE))
      else $error("no auto-restart");
endmodule

bind pss_sequencer pss_sequencer_assertions #(.OCP_CYC(OCP_CYC),
   .SOFT_CYC(SOFT_CYC), .BO_CYC(BO_CYC)) pss_sequencer_assertions_inst (
   .mclk_i(mclk_i), .rst_i(rst_i), .levels_i(levels_i), .sec_i(sec_i),
   .source_en_o(source_en_o), .drive_o(drive_o),
   .startup_overcurrent_flag_o(startup_overcurrent_flag_o),
   .protect_flag_o(protect_flag_o), .brownout_o(brownout_o),
   .state_o(state_o));

// *** pss_sequencer_bench.sv ***
/* Self-checking bench for the start-up sequencer.
 * Assumes short timers set here and the secondary model. */
`timescale 1ns/100ps
module pss_sequencer_bench;
   import pss_pkg::*;
   localparam int unsigned OCP  = 4000;
   localparam int unsigned SOFT = 2560;
   localparam int unsigned BO   = 50;
   logic        mclk_i = 1'b0;
   logic        rst_i  = 1'b1;
   pss_levels_t lv     = '0;
   pss_sec_t    sec;
   pss_drive_t  drv;
   pss_state_t  st;
   logic        src, ocp_f, prot_f, bo_f;
   logic [1:0]  mode   = 2'h2;
   logic [7:0]  dly    = 8'h0a;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          n;
   int          m;

   always #2 mclk_i = ~mclk_i;

   pss_sec_model pss_sec_model_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .mode_i(mode), .delay_i(dly), .switch_i(drv.switch_en), .sec_o(sec));
   pss_sequencer #(.OCP_CYC(OCP), .SOFT_CYC(SOFT), .BO_CYC(BO))
      pss_sequencer_inst (.mclk_i(mclk_i), .rst_i(rst_i), .levels_i(lv),
      .sec_i(sec), .source_en_o(src), .drive_o(drv),
      .startup_overcurrent_flag_o(ocp_f), .protect_flag_o(prot_f),
      .brownout_o(bo_f), .state_o(st));

   task automatic final_report();
      $display("Compared %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         final_report();
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wait_st(input pss_state_t s, output int k);
      k = 0;
      while (st !== s && k < 3000) begin
         tick(1);
         k++;
      end
      check(st, s);
   endtask

   function automatic pss_state_t exp_st(input logic [1:0] md);
      case (md)
         2'h1, 2'h3: exp_st = PSS_SECONDARY;
         2'h2:       exp_st = PSS_PROTECT;
         default:    exp_st = PSS_AUTONOMOUS;
      endcase
   endfunction

   task automatic do_reset();
      rst_i = 1'b1;
      lv = '0;
      tick(5);
      rst_i = 1'b0;
      check({src, drv, st},
         {3'b000, PEAK_LIMIT_FLOOR_MV, FREQ_SOFT_KHZ, PSS_CHARGE});
   endtask

   task automatic bring_up(input logic bi);
      lv.line_powered = 1'b1;
      lv.above_brownout = 1'b1;
      lv.above_brown_in = bi;
      tick(6);
      check(src, 1'b1);
      lv.above_source_off = 1'b1;
      wait_st(PSS_QUALIFY, n);
      check(src, 1'b0);
   endtask

   // Rail cycles once in brownout; bi is the line level at requalify
   task automatic hiccup(input logic bi);
      lv.above_source_off = 1'b0;
      lv.below_rail_min = 1'b1;
      tick(6);
      check({src, st}, {1'b1, PSS_BROWNOUT});
      lv.below_rail_min = 1'b0;
      lv.above_brown_in = bi;
      lv.above_source_off = 1'b1;
      wait_st(PSS_QUALIFY, n);
   endtask

   task automatic finish(input logic [1:0] md);
      if (md == 2'h3) begin
         wait_st(PSS_AUTONOMOUS, n);
         wait_st(PSS_SECONDARY, n);
         check(n <= dly + 8, 1'b1);
      end
      wait_st(exp_st(md), n);
      tick(2);
      case (md)
         2'h2: begin
            check({prot_f, drv.switch_en}, 2'b10);
            lv.above_source_off = 1'b0;
            lv.below_auto_restart = 1'b1;
            wait_st(PSS_CHARGE, n);
            tick(2);
            check({prot_f, ocp_f}, 2'b00);
            lv.below_auto_restart = 1'b0;
         end
         2'h0: begin
            check({drv.switch_en, drv.autonomous,
               drv.peak_limit_mv, drv.freq_khz},
               {2'b11, PEAK_LIMIT_FLOOR_MV, FREQ_SOFT_KHZ});
            tick(SOFT + 20);
            check({drv.peak_limit_mv, drv.freq_khz},
               {PEAK_LIMIT_CEILING_MV, FREQ_MAX_KHZ});
            wait_st(PSS_PROTECT, n);
            n = n + SOFT + 22;
            check(n + 2 >= OCP && n <= OCP + 3, 1'b1);
            tick(2);
            check({ocp_f, drv.switch_en}, 2'b10);
         end
         default: check(drv.autonomous, 1'b0);
      endcase
   endtask

   initial begin
      m = $urandom(10);
      do_reset();
      bring_up(1'b0);
      wait_st(PSS_BROWNOUT, n);
      tick(2);
      check(drv.switch_en, 1'b0);
      hiccup(1'b1);
      finish(2'h2);
      mode = 2'h1;
      bring_up(1'b1);
      finish(2'h1);
      // Short dip must clear the timer
      lv.above_brownout = 1'b0;
      tick(BO / 2);
      lv.above_brownout = 1'b1;
      tick(2);
      lv.above_brownout = 1'b0;
      wait_st(PSS_BROWNOUT, n);
      check(n >= BO && n <= BO + 6, 1'b1);
      tick(2);
      check({bo_f, prot_f, drv.switch_en}, 3'b110);
      lv.above_brownout = 1'b1;
      // No brown-in after brownout: must fall back to brownout
      hiccup(1'b0);
      wait_st(PSS_BROWNOUT, n);
      tick(4);
      check({st, bo_f}, {PSS_BROWNOUT, 1'b1});
      hiccup(1'b1);
      finish(2'h1);
      mode = 2'h0;
      do_reset();
      bring_up(1'b1);
      finish(2'h0);
      // Late secondary wake-up, independent of the random draws
      mode = 2'h3;
      do_reset();
      bring_up(1'b1);
      finish(2'h3);
      repeat (4) begin
         mode = 2'($urandom_range(3, 1));
         dly = 8'($urandom_range(60, 10));
         do_reset();
         bring_up(1'b1);
         finish(mode);
      end
      final_report();
   end
endmodule
